// File: l0pr_cap_reg.sv
`timescale 1ns/10ps
`default_nettype none
`include "l0pr_defines.svh"
module l0pr_cap_reg
#(
  parameter logic [7:0] MASK = 8'hFF
)(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [7:0] din,
  output logic      [7:0] dout
);
  logic [7:0] val_q;
  logic [7:0] val_d;

  // reserved bits never store, so they always read zero
  always_comb
  begin
    val_d = val_q;
    if (load)
    begin
      val_d = din & MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      val_q <= `L0PR_RO_RESET;
    end
    else
    begin
      val_q <= val_d;
    end
  end

  assign dout = val_q;
endmodule
`default_nettype wire

// File: l0pr_defines.svh
`ifndef L0PR_DEFINES_SVH
`define L0PR_DEFINES_SVH

// register offsets of the read-only bank
`define L0PR_OFS_LANE_ID     12'h402
`define L0PR_OFS_SCR_LANES   12'h403
`define L0PR_OFS_OCTETS      12'h404
`define L0PR_OFS_FRAMES      12'h405
`define L0PR_OFS_CONVERTERS  12'h406
`define L0PR_OFS_CTRL_RES    12'h407
`define L0PR_OFS_SUBCL_NP    12'h408
`define L0PR_OFS_VER_SAMPLES 12'h409
`define L0PR_OFS_DENSITY     12'h40A

// bank size and value of every field after reset
`define L0PR_NUM_REGS        9
`define L0PR_RO_RESET        8'h00

// octet positions in the lane 0 setup sequence
`define L0PR_OCT_DEV_ID      4'h0
`define L0PR_OCT_LANE_ID     4'h2
`define L0PR_OCT_LAST        4'hA

// field positions inside an octet
`define L0PR_TOP_BIT         7
`define L0PR_HI3_MSB         7
`define L0PR_HI3_LSB         5
`define L0PR_CS_LSB          6
`define L0PR_LO5_MSB         4

// readable-bit masks, lane id register in the low byte
`define L0PR_RO_MASKS        72'h9F_FF_FF_DF_FF_1F_FF_9F_1F

// legal encodings of the value-minus-one counts
`define L0PR_F_ONE           8'h00
`define L0PR_F_TWO           8'h01
`define L0PR_F_FOUR          8'h03
`define L0PR_K_16            5'h0F
`define L0PR_K_32            5'h1F
`define L0PR_M_MAX           8'h01
`define L0PR_CS_ZERO         2'h0
`define L0PR_N_16            5'h0F
`define L0PR_NP_16           5'h0F
`define L0PR_S_MAX           5'h01

`endif

// File: l0pr_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// setup octet stream from the link transmitter to lane 0 of the receiver
interface l0pr_link_if;
  logic       cfg_valid;
  logic       cfg_first;
  logic [7:0] cfg_octet;

  modport tx (output cfg_valid, output cfg_first, output cfg_octet);
  modport rx (input cfg_valid, input cfg_first, input cfg_octet);
endinterface
`default_nettype wire

// File: l0pr_link_rx.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - lane 0 parameters stored read-only, zero after reset
// - lane id in five low bits
// - scrambling flag in top bit
// - lane count minus one, five bits
// - octets per frame minus one: 0,1,3
// - frames per multiframe minus one: 0x0F,0x1F
// - transmitter sends converter count minus one: 0 or 1
// - transmitter sends zero control bits, top two bits
// - resolution minus one, only 0x0F
// - subclass in three upper bits
// - bits per sample minus one, only 0x0F
// - version field: 000 original, 001 B
// - samples per frame minus one: 0 or 1
// - high density flag in top bit
`include "l0pr_defines.svh"
module l0pr_link_rx
  import l0pr_pkg::*;
#(
  parameter int unsigned NUM_REGS = `L0PR_NUM_REGS
)(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  l0pr_link_if.rx          link,
  input  wire logic        rd_en,
  input  wire logic [11:0] rd_addr,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  output logic             setup_active,
  output logic             setup_done,
  output logic             param_err,
  output l0pr_cfg_t        rx_cfg,
  output logic      [4:0]  rx_lane_zero_ident,
  output logic             rx_scramble_flag,
  output logic      [2:0]  rx_subclass_version,
  output logic      [4:0]  rx_total_bits_per_sample_m1,
  output logic      [2:0]  rx_link_version,
  output logic             rx_high_density_flag
);
  localparam logic [8*`L0PR_NUM_REGS-1:0] MASKS = `L0PR_RO_MASKS;

  logic       active_q;
  logic       active_d;
  logic [3:0] idx_q;
  logic [3:0] idx_d;
  logic       done_q;
  logic       done_d;
  logic       err_q;
  logic       err_d;
  logic [7:0] rdat_q;
  logic [7:0] rdat_d;
  logic       rval_q;
  logic       rval_d;
  logic [3:0] cur_idx;
  logic       take;
  logic       cfg_ok;
  logic [7:0] bank [NUM_REGS];
  logic [11:0] rd_rel;

  // a first octet always restarts the sequence; stray octets are ignored
  always_comb
  begin
    cur_idx  = link.cfg_first ? `L0PR_OCT_DEV_ID : idx_q;
    take     = link.cfg_valid && (link.cfg_first || active_q);
    active_d = active_q;
    idx_d    = idx_q;
    done_d   = 1'b0;
    if (take)
    begin
      idx_d    = cur_idx + 4'h1;
      active_d = (cur_idx != `L0PR_OCT_LAST);
      done_d   = (cur_idx == `L0PR_OCT_LAST);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_q <= 1'b0;
      idx_q    <= 4'h0;
      done_q   <= 1'b0;
    end
    else
    begin
      active_q <= active_d;
      idx_q    <= idx_d;
      done_q   <= done_d;
    end
  end

  // one capture register per octet from lane id to density
  generate
    for (genvar i = 0; i < NUM_REGS; i++)
    begin : g_bank
      logic load;
      assign load = take && (cur_idx == `L0PR_OCT_LANE_ID + 4'(i));
      l0pr_cap_reg #(
        .MASK (MASKS[8*i +: 8])
      ) u_reg (
        .mclk  (mclk),
        .rst_n (rst_n),
        .load  (load),
        .din   (link.cfg_octet),
        .dout  (bank[i])
      );
    end
  endgenerate

  // field view of the bank
  assign rx_cfg.lane_id      = bank[0][`L0PR_LO5_MSB:0];
  assign rx_cfg.scramble     = bank[1][`L0PR_TOP_BIT];
  assign rx_cfg.lanes_m1     = bank[1][`L0PR_LO5_MSB:0];
  assign rx_cfg.octets_m1    = bank[2];
  assign rx_cfg.frames_m1    = bank[3][`L0PR_LO5_MSB:0];
  assign rx_cfg.conv_m1      = bank[4];
  assign rx_cfg.ctrl_bits    = bank[5][`L0PR_TOP_BIT:`L0PR_CS_LSB];
  assign rx_cfg.res_m1       = bank[5][`L0PR_LO5_MSB:0];
  assign rx_cfg.subclass     = bank[6][`L0PR_HI3_MSB:`L0PR_HI3_LSB];
  assign rx_cfg.bits_m1      = bank[6][`L0PR_LO5_MSB:0];
  assign rx_cfg.version      = bank[7][`L0PR_HI3_MSB:`L0PR_HI3_LSB];
  assign rx_cfg.samples_m1   = bank[7][`L0PR_LO5_MSB:0];
  assign rx_cfg.high_density = bank[8][`L0PR_TOP_BIT];
  assign rx_cfg.ctrl_words   = bank[8][`L0PR_LO5_MSB:0];

  assign rx_lane_zero_ident          = rx_cfg.lane_id;
  assign rx_scramble_flag            = rx_cfg.scramble;
  assign rx_subclass_version         = rx_cfg.subclass;
  assign rx_total_bits_per_sample_m1 = rx_cfg.bits_m1;
  assign rx_link_version             = rx_cfg.version;
  assign rx_high_density_flag        = rx_cfg.high_density;

  // legality of what the transmitter advertised
  always_comb
  begin
    cfg_ok = 1'b1;
    if (!(rx_cfg.octets_m1 == `L0PR_F_ONE || rx_cfg.octets_m1 == `L0PR_F_TWO
          || rx_cfg.octets_m1 == `L0PR_F_FOUR))
    begin
      cfg_ok = 1'b0;
    end
    if (!(rx_cfg.frames_m1 == `L0PR_K_16 || rx_cfg.frames_m1 == `L0PR_K_32))
    begin
      cfg_ok = 1'b0;
    end
    if (rx_cfg.conv_m1 > `L0PR_M_MAX)
    begin
      cfg_ok = 1'b0;
    end
    if (rx_cfg.ctrl_bits != `L0PR_CS_ZERO)
    begin
      cfg_ok = 1'b0;
    end
    if (rx_cfg.res_m1 != `L0PR_N_16)
    begin
      cfg_ok = 1'b0;
    end
    if (rx_cfg.bits_m1 != `L0PR_NP_16)
    begin
      cfg_ok = 1'b0;
    end
    if (rx_cfg.samples_m1 > `L0PR_S_MAX)
    begin
      cfg_ok = 1'b0;
    end
  end

  // checked one cycle after the last octet, once the bank has settled;
  // a new sequence clears the flag, the judgement at its end sets it again only for an illegal set
  always_comb
  begin
    err_d = err_q;
    if (take && link.cfg_first)
    begin
      err_d = 1'b0;
    end
    if (done_q)
    begin
      err_d = !cfg_ok;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_q <= 1'b0;
    end
    else
    begin
      err_q <= err_d;
    end
  end

  // read port: answer one cycle later, unmapped offsets read zero
  always_comb
  begin
    rd_rel = rd_addr - `L0PR_OFS_LANE_ID;
    rdat_d = rdat_q;
    rval_d = rd_en;
    if (rd_en)
    begin
      rdat_d = 8'h00;
      if (rd_addr >= `L0PR_OFS_LANE_ID && rd_addr <= `L0PR_OFS_DENSITY)
      begin
        rdat_d = bank[rd_rel[3:0]];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdat_q <= 8'h00;
      rval_q <= 1'b0;
    end
    else
    begin
      rdat_q <= rdat_d;
      rval_q <= rval_d;
    end
  end

  assign rd_data      = rdat_q;
  assign rd_valid     = rval_q;
  assign setup_active = active_q;
  assign setup_done   = done_q;
  assign param_err    = err_q;
endmodule
`default_nettype wire

// File: l0pr_link_tx.sv
`timescale 1ns/10ps
`default_nettype none
`include "l0pr_defines.svh"
module l0pr_link_tx
  import l0pr_pkg::*;
#(
  parameter logic [7:0] DEV_ID  = 8'h00, // arbitrary
  parameter logic [7:0] BANK_ID = 8'h00  // arbitrary
)(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  l0pr_link_if.tx         link,
  input  wire logic       send_req,
  input  wire l0pr_cfg_t  cfg,
  output logic            busy,
  output logic            req_err
);
  l0pr_tx_state_t state_q;
  l0pr_tx_state_t state_d;
  l0pr_cfg_t      cfg_q;
  l0pr_cfg_t      cfg_d;
  logic [3:0]     idx_q;
  logic [3:0]     idx_d;
  logic           val_q;
  logic           val_d;
  logic           first_q;
  logic           first_d;
  logic [7:0]     oct_q;
  logic [7:0]     oct_d;
  logic           cfg_ok;
  logic [7:0]     oct_cur;

  // only legal parameter sets may go out on the link
  always_comb
  begin
    cfg_ok = (cfg.octets_m1 == `L0PR_F_ONE || cfg.octets_m1 == `L0PR_F_TWO
              || cfg.octets_m1 == `L0PR_F_FOUR)
          && (cfg.frames_m1 == `L0PR_K_16 || cfg.frames_m1 == `L0PR_K_32)
          && (cfg.conv_m1 <= `L0PR_M_MAX)
          && (cfg.ctrl_bits == `L0PR_CS_ZERO)
          && (cfg.res_m1 == `L0PR_N_16)
          && (cfg.bits_m1 == `L0PR_NP_16)
          && (cfg.samples_m1 <= `L0PR_S_MAX);
  end

  // octet layout of the setup sequence
  always_comb
  begin
    case (idx_q)
      4'h0:    oct_cur = DEV_ID;
      4'h1:    oct_cur = BANK_ID;
      4'h2:    oct_cur = {3'b000, cfg_q.lane_id};
      4'h3:    oct_cur = {cfg_q.scramble, 2'b00, cfg_q.lanes_m1};
      4'h4:    oct_cur = cfg_q.octets_m1;
      4'h5:    oct_cur = {3'b000, cfg_q.frames_m1};
      4'h6:    oct_cur = cfg_q.conv_m1;
      4'h7:    oct_cur = {cfg_q.ctrl_bits, 1'b0, cfg_q.res_m1};
      4'h8:    oct_cur = {cfg_q.subclass, cfg_q.bits_m1};
      4'h9:    oct_cur = {cfg_q.version, cfg_q.samples_m1};
      4'hA:    oct_cur = {cfg_q.high_density, 2'b00, cfg_q.ctrl_words};
      default: oct_cur = 8'h00;
    endcase
  end

  // parameters are latched at the request so the sequence is coherent
  always_comb
  begin
    state_d = state_q;
    cfg_d   = cfg_q;
    idx_d   = idx_q;
    val_d   = 1'b0;
    first_d = 1'b0;
    oct_d   = oct_q;
    req_err = 1'b0;
    case (state_q)
      L0PR_TX_IDLE:
      begin
        if (send_req && !val_q)
        begin
          if (cfg_ok)
          begin
            state_d = L0PR_TX_SEND;
            cfg_d   = cfg;
            idx_d   = `L0PR_OCT_DEV_ID;
          end
          else
          begin
            req_err = 1'b1;
          end
        end
      end
      L0PR_TX_SEND:
      begin
        val_d   = 1'b1;
        first_d = (idx_q == `L0PR_OCT_DEV_ID);
        oct_d   = oct_cur;
        idx_d   = idx_q + 4'h1;
        if (idx_q == `L0PR_OCT_LAST)
        begin
          state_d = L0PR_TX_IDLE;
        end
      end
      default:
      begin
        state_d = L0PR_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= L0PR_TX_IDLE;
      cfg_q   <= '0;
      idx_q   <= 4'h0;
      val_q   <= 1'b0;
      first_q <= 1'b0;
      oct_q   <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      cfg_q   <= cfg_d;
      idx_q   <= idx_d;
      val_q   <= val_d;
      first_q <= first_d;
      oct_q   <= oct_d;
    end
  end

  assign link.cfg_valid = val_q;
  assign link.cfg_first = first_q;
  assign link.cfg_octet = oct_q;
  assign busy           = (state_q != L0PR_TX_IDLE) || val_q;
endmodule
`default_nettype wire

// File: l0pr_pkg.sv
`default_nettype none
package l0pr_pkg;

  typedef logic [7:0] l0pr_octet_t;

  // link parameters as carried on the link, counts held minus one
  typedef struct packed {
    logic [4:0] lane_id;
    logic       scramble;
    logic [4:0] lanes_m1;
    logic [7:0] octets_m1;
    logic [4:0] frames_m1;
    logic [7:0] conv_m1;
    logic [1:0] ctrl_bits;
    logic [4:0] res_m1;
    logic [2:0] subclass;
    logic [4:0] bits_m1;
    logic [2:0] version;
    logic [4:0] samples_m1;
    logic       high_density;
    logic [4:0] ctrl_words;
  } l0pr_cfg_t;

  typedef enum logic {L0PR_TX_IDLE, L0PR_TX_SEND} l0pr_tx_state_t;

endpackage
`default_nettype wire

// File: l0pr_props.sv
`timescale 1ns/10ps
`default_nettype none
module l0pr_props (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       cfg_valid,
  input wire logic       cfg_first,
  input wire logic [7:0] cfg_octet
);
  logic [3:0] idx_q;
  logic [3:0] idx_d;
  logic       mid;

  // index of the next octet; parks at 11 so stray octets match no field
  always_comb
  begin
    idx_d = idx_q;
    if (cfg_valid && cfg_first)
    begin
      idx_d = 4'h1;
    end
    else if (cfg_valid && idx_q != 4'hB)
    begin
      idx_d = idx_q + 4'h1;
    end
  end

  // index register, parked until the first start mark
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_q <= 4'hB;
    end
    else
    begin
      idx_q <= idx_d;
    end
  end
  assign mid = cfg_valid && !cfg_first;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_first_has_valid: assert property (cfg_first |-> cfg_valid)
    else $error("start mark without valid octet");
  a_frame_eleven: assert property (cfg_valid && cfg_first |=> mid [*8] ##1 mid [*2]
    ##1 !cfg_valid)
    else $error("setup frame is not eleven octets");
  a_octets_legal: assert property (mid && idx_q == 4'h4 |->
    cfg_octet inside {8'h00, 8'h01, 8'h03})
    else $error("octets per frame code illegal");
  a_frames_legal: assert property (mid && idx_q == 4'h5 |->
    cfg_octet inside {8'h0F, 8'h1F})
    else $error("frames per multiframe code illegal");
  a_conv_legal: assert property (mid && idx_q == 4'h6 |-> cfg_octet <= 8'h01)
    else $error("converter count code illegal");
  a_ctrl_res_ok: assert property (mid && idx_q == 4'h7 |->
    cfg_octet[7:6] == 2'h0 && cfg_octet[4:0] == 5'h0F)
    else $error("control bits or resolution illegal");
  a_sample_bits_ok: assert property (mid && idx_q == 4'h8 |-> cfg_octet[4:0] == 5'h0F)
    else $error("bits per sample code illegal");
  a_samples_legal: assert property (mid && idx_q == 4'h9 |-> cfg_octet[4:0] <= 5'h01)
    else $error("samples per frame code illegal");

  c_frame_start: cover property (cfg_valid && cfg_first);
  c_last_octet: cover property (mid && idx_q == 4'hA);
  c_four_octets: cover property (mid && idx_q == 4'h4 && cfg_octet == 8'h03);
endmodule
`default_nettype wire

// File: test_lane0_link_param_readback.sv
`timescale 1ns/10ps
`default_nettype none
module test_lane0_link_param_readback
  import l0pr_pkg::*;
;
  logic        mclk, rst_n, send_req, busy, req_err, rd_en, rd_valid;
  logic        setup_done, param_err, param_err2, scr, hd, act;
  logic [11:0] rd_addr;
  logic [7:0]  rd_data;
  logic [4:0]  lid, np;
  logic [2:0]  sub, ver;
  l0pr_cfg_t   cfg, rx_cfg2, c;
  int          err_total, n_compared, n, k;

  l0pr_link_if u_link ();
  l0pr_link_if u_link2 ();

  l0pr_link_tx i_l0pr_link_tx (.mclk(mclk), .rst_n(rst_n), .link(u_link.tx),
    .send_req(send_req), .cfg(cfg), .busy(busy), .req_err(req_err));
  l0pr_link_rx i_l0pr_link_rx (.mclk(mclk), .rst_n(rst_n), .link(u_link.rx),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .setup_active(act), .setup_done(setup_done), .param_err(param_err), .rx_cfg(),
    .rx_lane_zero_ident(lid), .rx_scramble_flag(scr), .rx_subclass_version(sub),
    .rx_total_bits_per_sample_m1(np), .rx_link_version(ver), .rx_high_density_flag(hd));
  // second receiver faces a bench driver that breaks the transmitter's limits
  l0pr_link_rx i_l0pr_link_rx2 (.mclk(mclk), .rst_n(rst_n), .link(u_link2.rx),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(), .rd_valid(), .setup_active(),
    .setup_done(), .param_err(param_err2), .rx_cfg(rx_cfg2), .rx_lane_zero_ident(),
    .rx_scramble_flag(), .rx_subclass_version(), .rx_total_bits_per_sample_m1(),
    .rx_link_version(), .rx_high_density_flag());
  l0pr_props i_l0pr_props (.mclk(mclk), .rst_n(rst_n), .cfg_valid(u_link.cfg_valid),
    .cfg_first(u_link.cfg_first), .cfg_octet(u_link.cfg_octet));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // register image of a parameter set, reserved bits zero
  function automatic logic [7:0] ex(input l0pr_cfg_t p, input int i);
    case (i)
      2: ex = {3'h0, p.lane_id};
      3: ex = {p.scramble, 2'h0, p.lanes_m1};
      4: ex = p.octets_m1;
      5: ex = {3'h0, p.frames_m1};
      6: ex = p.conv_m1;
      7: ex = {p.ctrl_bits, 1'b0, p.res_m1};
      8: ex = {p.subclass, p.bits_m1};
      9: ex = {p.version, p.samples_m1};
      10: ex = {p.high_density, 2'h0, p.ctrl_words};
      default: ex = 8'h00;
    endcase
  endfunction

  // hi picks the upper legal code of each varying field; octets from oct, resolution and sample bits fixed at 0x0F
  function automatic l0pr_cfg_t mk(input logic [7:0] oct, input logic hi);
    mk = '0;
    mk.lane_id = {hi, 4'h5};
    mk.scramble = hi;
    mk.lanes_m1 = {4'h0, hi};
    mk.octets_m1 = oct;
    mk.frames_m1 = {hi, 4'hF};
    mk.conv_m1 = {7'h00, hi};
    mk.res_m1 = 5'h0F;
    mk.subclass = {2'h0, hi};
    mk.bits_m1 = 5'h0F;
    mk.version = {2'h0, hi};
    mk.samples_m1 = {4'h0, hi};
    mk.high_density = hi;
  endfunction

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge mclk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge mclk);
    rd_en = 1'b0;
    check({7'h00, rd_valid}, 8'h01);
    check(rd_data, exp);
  endtask

  task automatic readall(input l0pr_cfg_t p);
    int i;
    for (i = 2; i <= 10; i++)
      rd(12'h400 + 12'(i), ex(p, i));
  endtask

  task automatic send(input l0pr_cfg_t p);
    int i;
    @(negedge mclk);
    cfg = p;
    send_req = 1'b1;
    #1 check({7'h00, req_err}, 8'h00);
    @(negedge mclk);
    send_req = 1'b0;
    check({7'h00, busy}, 8'h01);
    // a timeout counts as a mismatch; the run still ends at the verdict
    for (i = 0; i < 40 && setup_done !== 1'b1; i++)
    begin
      if (i == 5)
        check({7'h00, act}, 8'h01);
      @(negedge mclk);
    end
    if (i == 40)
    begin
      err_total++;
    end
    check({6'h00, busy, act}, 8'h00);
    @(negedge mclk);
  endtask

  // hand-driven frame; the released data line shows the inverse of its last value
  task automatic drive2(input l0pr_cfg_t p);
    int i;
    for (i = 0; i < 11; i++)
    begin
      @(negedge mclk);
      u_link2.cfg_valid = 1'b1;
      u_link2.cfg_first = (i == 0);
      u_link2.cfg_octet = ex(p, i);
    end
    @(negedge mclk);
    u_link2.cfg_valid = 1'b0;
    u_link2.cfg_octet = ~u_link2.cfg_octet;
    repeat (3) @(negedge mclk);
  endtask

  initial
  begin
    err_total = 0;
    n_compared = 0;
    rst_n = 1'b0;
    send_req = 1'b0;
    cfg = '0;
    rd_en = 1'b0;
    rd_addr = 12'h000;
    u_link2.cfg_valid = 1'b0;
    u_link2.cfg_first = 1'b0;
    u_link2.cfg_octet = 8'h00;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    for (n = 2; n <= 10; n++)
      rd(12'h400 + 12'(n), 8'h00);
    // every legal octets-per-frame code, alternating low and high field codes
    for (k = 0; k < 3; k++)
    begin
      c = mk((k == 0) ? 8'h03 : 8'(k - 1), k != 1);
      send(c);
      readall(c);
      check({7'h00, param_err}, 8'h00);
      check({scr, hd, ver, sub}, {c.scramble, c.high_density, c.version, c.subclass});
      check({3'h0, lid}, {3'h0, c.lane_id});
      check({3'h0, np}, 8'h0F);
    end
    @(negedge mclk);
    cfg = mk(8'h02, 1'b0);
    send_req = 1'b1;
    #1 check({7'h00, req_err}, 8'h01);
    @(negedge mclk);
    send_req = 1'b0;
    repeat (3) @(negedge mclk);
    readall(c);
    rd(12'h401, 8'h00);
    rd(12'h40B, 8'h00);
    c = mk(8'h00, 1'b0);
    c.conv_m1 = 8'h05;
    c.ctrl_bits = 2'h2;
    drive2(c);
    check(rx_cfg2.conv_m1, 8'h05);
    check({6'h00, rx_cfg2.ctrl_bits}, 8'h02);
    check({7'h00, param_err2}, 8'h01);
    // stray octets without a start mark must leave the capture alone
    @(negedge mclk);
    u_link2.cfg_valid = 1'b1;
    repeat (12) @(negedge mclk);
    u_link2.cfg_valid = 1'b0;
    check(rx_cfg2.conv_m1, 8'h05);
    // a fresh legal sequence clears the error flag
    c = mk(8'h01, 1'b1);
    drive2(c);
    check({7'h00, param_err2}, 8'h00);
    check(rx_cfg2.conv_m1, 8'h01);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    rd(12'h406, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
